// ---- tpos_ctrl_model.sv ----
// partner model: frame controller that accepts transmit requests
module tpos_ctrl_model
(
  // clock
  input  wire logic clock_i,
  // pacing: low acks promptly, high makes the request wait
  input  wire logic slow_i,
  // frame request
  input  wire logic tx_req_i,
  output logic      tx_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt = 0;
  initial tx_ack_o = 1'b0;
  // ack is a one-cycle pulse, never given twice for one request
  always @(posedge clock_i)
  begin
    tx_ack_o <= 1'b0;
    if (tx_req_i === 1'b1 && !tx_ack_o)
    begin
      if (wait_cnt >= (slow_i ? 6 : 1))
      begin
        tx_ack_o <= 1'b1;
        wait_cnt <= 0;
      end
      else
        wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// ---- tpos_pkg.sv ----
// package: register map, field layout, reset values and timing constants of the tx scheduler
//
// Behaviour
// - two independent transmit objects, each sending at most eight payload bytes
// - comm record reports highest sub-entry 5 (read-only)
// - frames carry the object's identifier; defaults 180h/280h plus node number
// - type 0: send right after every received sync
// - type 1..240: send once every N received syncs
// - type 252: latch payload on sync, send on matching remote request
// - type 253: refresh payload and send on matching remote request
// - type 254 (reset default): send periodically on the event timer
// - type 255: send on any mapped value change, plus event timer if non-zero
// - inhibit time in 100 us units blocks sends after each frame; 0 disables
// - non-zero event timer in 1 ms units triggers sends on expiry; 0 disables
// - objects send and accept only while the node is operational
// - map table holds at most four entries totalling at most eight bytes
// - map entry: index [31:16], sub-entry [15:8], size in bits [7:0]
// - count 0 disables the object; entries edited; new count re-enables it
// - identifier bit 31 set disables the object
// - identifier bits 10..0 hold the frame id; bits 28..11 read zero
// - sync frames recognised by a configurable identifier, default 80h
package tpos_pkg;

  localparam int unsigned NUM_OBJ = 2;
  localparam int unsigned MAP_MAX = 4;
  localparam int unsigned PAYLOAD_BYTES = 8;

  // register offsets; word index = object * 16 + offset, object in addr[4]
  localparam logic [7:0] OFS_HIGHEST = 8'h00;
  localparam logic [7:0] OFS_IDENT = 8'h01;
  localparam logic [7:0] OFS_TYPE = 8'h02;
  localparam logic [7:0] OFS_INHIBIT = 8'h03;
  localparam logic [7:0] OFS_RSVD = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h05;
  localparam logic [7:0] OFS_MAP_CNT = 8'h08;
  localparam logic [7:0] OFS_MAP_ENT = 8'h09;
  localparam logic [7:0] OFS_SYNC_ID = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h21;

  localparam int unsigned OBJ_SEL_BIT = 4;

  // field positions
  localparam int unsigned ID_DIS_BIT = 31;
  localparam int unsigned ID_MSB = 10;
  localparam int unsigned MAP_SIZE_MSB = 7;

  // reset values
  localparam logic [7:0] HIGHEST_SUB = 8'h05;
  localparam logic [10:0] ID_BASE0 = 11'h180;
  localparam logic [10:0] ID_BASE1 = 11'h280;
  localparam logic [7:0] TYPE_RST = 8'hFE;
  localparam logic [10:0] SYNC_ID_RST = 11'h080;

  // transmission types
  localparam logic [7:0] TT_ACYC = 8'h00;
  localparam logic [7:0] TT_CYC_MAX = 8'hF0;
  localparam logic [7:0] TT_RTR_SYNC = 8'hFC;
  localparam logic [7:0] TT_RTR = 8'hFD;
  localparam logic [7:0] TT_TIMER = 8'hFE;
  localparam logic [7:0] TT_COS = 8'hFF;

  // time bases
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_US = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000000 * TICK_US;
  localparam int unsigned MS_PER_TICKS = 10;

endpackage

// ---- tpos_top.sv ----
// transmit object scheduler: two objects, comm records, map tables, timers, frame request out
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
module tpos_top
#(
  parameter int unsigned TICK_CYCLES = tpos_pkg::TICK_CYC,
  parameter logic [6:0]  NODE_ID     = 7'h01
)
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // network state and received frames
  input  wire logic        operational_i,
  input  wire logic        rx_valid_i,
  input  wire logic [10:0] rx_id_i,
  input  wire logic        rx_remote_i,
  // mapped object values, 8 bytes per object
  input  wire logic [63:0] obj0_data_i,
  input  wire logic [63:0] obj1_data_i,
  // frame request to the controller
  output logic             tx_req_o,
  output logic      [10:0] tx_id_o,
  output logic      [3:0]  tx_len_o,
  output logic      [63:0] tx_data_o,
  input  wire logic        tx_ack_i
);

  localparam int unsigned N = tpos_pkg::NUM_OBJ;
  localparam int unsigned M = tpos_pkg::MAP_MAX;

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_n = rst_sync_r[1];

  // ****************************************
  // time bases
  // ****************************************
  logic [15:0] pre_r;
  logic [3:0]  ms_div_r;
  logic        tick100_r;
  logic        tick1ms_r;
  wire         pre_end = (pre_r == 16'(TICK_CYCLES - 1));
  wire         ms_end = pre_end && (ms_div_r == 4'(tpos_pkg::MS_PER_TICKS - 1));

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_r <= 16'h0000;
      ms_div_r <= 4'h0;
      tick100_r <= 1'b0;
      tick1ms_r <= 1'b0;
    end
    else
    begin
      pre_r <= pre_end ? 16'h0000 : pre_r + 16'h0001;
      if (pre_end)
        ms_div_r <= ms_end ? 4'h0 : ms_div_r + 4'h1;
      tick100_r <= pre_end;
      tick1ms_r <= ms_end;
    end
  end

  // ****************************************
  // register decode
  // ****************************************
  wire       obj_sel = reg_addr_i[tpos_pkg::OBJ_SEL_BIT];
  wire [7:0] ofs = {4'h0, reg_addr_i[3:0]};
  wire       glb = reg_addr_i[5];
  logic [10:0] sync_id_r;

  function automatic logic hit(input logic [7:0] o);
    hit = !glb && (ofs == o);
  endfunction

  // map size sum in bytes for a count and table
  function automatic logic [7:0] map_bytes(input logic [2:0] cnt, input logic [127:0] tbl);
    logic [10:0] s;
    s = 11'h000;
    for (int k = 0; k < M; k++)
      if (k < cnt)
        s = s + {3'b000, tbl[k*32 +: 8]};
    map_bytes = s[10:3];
  endfunction

  wire sync_seen = rx_valid_i && !rx_remote_i && (rx_id_i == sync_id_r) && operational_i;

  logic [N-1:0] want_r;
  logic [N-1:0] grant;
  logic [N-1:0] obj_en;
  logic [31:0]  rd_obj [N];
  logic [10:0]  id_of [N];
  logic [3:0]   len_of [N];
  logic [63:0]  pay_of [N];

  // ****************************************
  // per-object logic
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : gobj
      logic [31:0]  ident_r;
      logic [7:0]   type_r;
      logic [15:0]  inhibit_r;
      logic [7:0]   rsvd_r;
      logic [15:0]  event_r;
      logic [2:0]   cnt_r;
      logic [127:0] map_r;
      logic [7:0]   sync_cnt_r;
      logic [15:0]  inh_cnt_r;
      logic [15:0]  evt_cnt_r;
      logic [63:0]  latch_r;
      logic [63:0]  prev_r;
      logic         pend_r;
      wire [63:0]   live = (g == 0) ? obj0_data_i : obj1_data_i;
      wire          wsel = reg_wr_i && (obj_sel == 1'(g));
      wire [7:0]    mofs = ofs - tpos_pkg::OFS_MAP_ENT;
      wire          map_wr = wsel && !glb && (ofs >= tpos_pkg::OFS_MAP_ENT)
                             && (mofs < 8'(M)) && (cnt_r == 3'h0);
      wire [7:0]    nbytes = map_bytes(cnt_r, map_r);
      wire          rtr_hit = rx_valid_i && rx_remote_i && operational_i
                              && (rx_id_i == ident_r[tpos_pkg::ID_MSB:0]);
      wire          is_cyc = (type_r != tpos_pkg::TT_ACYC) && (type_r <= tpos_pkg::TT_CYC_MAX);
      wire          is_async = (type_r == tpos_pkg::TT_TIMER) || (type_r == tpos_pkg::TT_COS);
      wire          sync_fire = sync_seen && ((type_r == tpos_pkg::TT_ACYC)
                                || (is_cyc && (sync_cnt_r + 8'h01 >= type_r)));
      wire          rtr_fire = rtr_hit && ((type_r == tpos_pkg::TT_RTR_SYNC)
                               || (type_r == tpos_pkg::TT_RTR));
      wire          evt_fire = is_async && (event_r != 16'h0000) && tick1ms_r
                               && (evt_cnt_r <= 16'h0001);
      wire          cos_fire = (type_r == tpos_pkg::TT_COS) && (live != prev_r);
      wire          inhibited = (inh_cnt_r != 16'h0000);

      assign obj_en[g] = !ident_r[tpos_pkg::ID_DIS_BIT] && (cnt_r != 3'h0)
                         && operational_i && (nbytes <= 8'(tpos_pkg::PAYLOAD_BYTES));
      assign id_of[g] = ident_r[tpos_pkg::ID_MSB:0];
      assign len_of[g] = nbytes[3:0];
      assign pay_of[g] = (type_r == tpos_pkg::TT_RTR_SYNC) ? latch_r : live;
      assign want_r[g] = pend_r && !inhibited && obj_en[g];

      always_comb
      begin
        rd_obj[g] = 32'h0000_0000;
        case (ofs)
          tpos_pkg::OFS_HIGHEST: rd_obj[g] = {24'h0, tpos_pkg::HIGHEST_SUB};
          tpos_pkg::OFS_IDENT:   rd_obj[g] = {ident_r[31], 20'h0, ident_r[10:0]};
          tpos_pkg::OFS_TYPE:    rd_obj[g] = {24'h0, type_r};
          tpos_pkg::OFS_INHIBIT: rd_obj[g] = {16'h0, inhibit_r};
          tpos_pkg::OFS_RSVD:    rd_obj[g] = {24'h0, rsvd_r};
          tpos_pkg::OFS_EVENT:   rd_obj[g] = {16'h0, event_r};
          tpos_pkg::OFS_MAP_CNT: rd_obj[g] = {29'h0, cnt_r};
          default:
            if ((ofs >= tpos_pkg::OFS_MAP_ENT) && (mofs < 8'(M)))
              rd_obj[g] = map_r[mofs[1:0]*32 +: 32];
        endcase
      end

      always_ff @(posedge clock_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          // default identifier carries the node number, as the network expects
          ident_r <= {21'h0, ((g == 0) ? tpos_pkg::ID_BASE0 : tpos_pkg::ID_BASE1)
                      + {4'h0, NODE_ID}};
          type_r <= tpos_pkg::TYPE_RST;
          inhibit_r <= 16'h0000;
          rsvd_r <= 8'h00;
          event_r <= 16'h0000;
          cnt_r <= 3'h0;
          map_r <= '0;
        end
        else
        begin
          if (wsel && hit(tpos_pkg::OFS_IDENT))
            ident_r <= {reg_wdata_i[31], 20'h0, reg_wdata_i[10:0]};
          if (wsel && hit(tpos_pkg::OFS_TYPE))
            type_r <= reg_wdata_i[7:0];
          if (wsel && hit(tpos_pkg::OFS_INHIBIT))
            inhibit_r <= reg_wdata_i[15:0];
          if (wsel && hit(tpos_pkg::OFS_RSVD))
            rsvd_r <= reg_wdata_i[7:0];
          if (wsel && hit(tpos_pkg::OFS_EVENT))
            event_r <= reg_wdata_i[15:0];
          if (wsel && hit(tpos_pkg::OFS_MAP_CNT) && (reg_wdata_i[7:0] <= 8'(M)))
            cnt_r <= reg_wdata_i[2:0];
          if (map_wr)
            map_r[mofs[1:0]*32 +: 32] <= reg_wdata_i;
        end
      end

      // trigger and timing state
      always_ff @(posedge clock_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync_cnt_r <= 8'h00;
          inh_cnt_r <= 16'h0000;
          evt_cnt_r <= 16'h0000;
          latch_r <= '0;
          prev_r <= '0;
          pend_r <= 1'b0;
        end
        else
        begin
          prev_r <= live;
          if (sync_seen && is_cyc)
            sync_cnt_r <= sync_fire ? 8'h00 : sync_cnt_r + 8'h01;
          if (sync_seen && (type_r == tpos_pkg::TT_RTR_SYNC))
            latch_r <= live;
          if (tick1ms_r)
            evt_cnt_r <= (evt_cnt_r <= 16'h0001) ? event_r : evt_cnt_r - 16'h0001;
          if (grant[g])
            inh_cnt_r <= inhibit_r;
          else if (tick100_r && inhibited)
            inh_cnt_r <= inh_cnt_r - 16'h0001;
          // new trigger beats the clear by grant
          if (!obj_en[g])
            pend_r <= 1'b0;
          else if (sync_fire || rtr_fire || evt_fire || cos_fire)
            pend_r <= 1'b1;
          else if (grant[g])
            pend_r <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // frame request, object 0 first
  // ****************************************
  wire pick = !want_r[0];
  assign grant[0] = !tx_req_o && want_r[0];
  assign grant[1] = !tx_req_o && !want_r[0] && want_r[1];

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_req_o <= 1'b0;
      tx_id_o <= 11'h000;
      tx_len_o <= 4'h0;
      tx_data_o <= '0;
    end
    else if (tx_req_o)
    begin
      if (tx_ack_i)
        tx_req_o <= 1'b0;
    end
    else if (|grant)
    begin
      tx_req_o <= 1'b1;
      tx_id_o <= id_of[pick];
      tx_len_o <= len_of[pick];
      tx_data_o <= pay_of[pick];
    end
  end

  // ****************************************
  // register read and sync id
  // ****************************************
  wire [31:0] rd_mux = !glb ? rd_obj[obj_sel]
                     : (reg_addr_i == tpos_pkg::OFS_SYNC_ID) ? {21'h0, sync_id_r}
                     : (reg_addr_i == tpos_pkg::OFS_STATUS) ? {28'h0, want_r, obj_en}
                     : 32'h0000_0000;

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_id_r <= tpos_pkg::SYNC_ID_RST;
      reg_rdata_o <= 32'h0000_0000;
    end
    else
    begin
      if (reg_wr_i && (reg_addr_i == tpos_pkg::OFS_SYNC_ID))
        sync_id_r <= reg_wdata_i[10:0];
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

// ---- tpos_top_sva.sv ----
// checker: port-level properties of the transmit object scheduler
module tpos_top_chk
(
  // clock and reset
  input wire logic        clock_i,
  input wire logic        resetn_i,
  // register port
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // network state and frame request
  input wire logic        operational_i,
  input wire logic        tx_req_o,
  input wire logic [10:0] tx_id_o,
  input wire logic [3:0]  tx_len_o,
  input wire logic [63:0] tx_data_o,
  input wire logic        tx_ack_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  req_hold_a: assert property (tx_req_o && !tx_ack_i |=> tx_req_o)
    else $error("frame request dropped before ack");
  frame_stable_a: assert property (tx_req_o && !tx_ack_i |=>
    $stable({tx_id_o, tx_len_o, tx_data_o})) else $error("frame changed while waiting");
  ack_clear_a: assert property (tx_req_o && tx_ack_i |=> !tx_req_o)
    else $error("request stayed after ack");
  len_max_a: assert property (tx_req_o |-> tx_len_o <= 4'h8)
    else $error("payload longer than eight bytes");
  idle_oper_a: assert property (!operational_i && !tx_req_o |=> !tx_req_o)
    else $error("frame started while not operational");
  highest_ro_a: assert property (reg_rd_i && reg_addr_i[7:5] == 3'h0
    && reg_addr_i[3:0] == 4'h0 |=> reg_rdata_o == 32'h5) else $error("highest entry wrong");
  id_zero_a: assert property (reg_rd_i && reg_addr_i[7:5] == 3'h0
    && reg_addr_i[3:0] == 4'h1 |=> reg_rdata_o[28:11] == 18'h0) else $error("id bits set");
  map_cnt_a: assert property (reg_rd_i && reg_addr_i[7:5] == 3'h0
    && reg_addr_i[3:0] == 4'h8 |=> reg_rdata_o <= 32'h4) else $error("map count above four");
endmodule

// ---- transmit_process_object_scheduler_tb.sv ----
// testbench: register, sync, remote, timer and change-of-state traffic
module transmit_process_object_scheduler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i, resetn_i, reg_wr_i, reg_rd_i, operational_i;
  logic        rx_valid_i, rx_remote_i, tx_req_o, tx_ack_i, slow;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [10:0] rx_id_i, tx_id_o;
  logic [63:0] obj0_data_i, obj1_data_i, tx_data_o;
  logic [3:0]  tx_len_o;
  logic [78:0] fq[$];
  int          tq[$];
  int          err_total = 0, checks_done = 0, cyc = 0, t_last = 0, t_prev = 0;
  int          nl[3] = '{1, 3, 240};

  tpos_top #(.TICK_CYCLES(40)) i_tpos_top (.clock_i, .resetn_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .operational_i, .rx_valid_i, .rx_id_i, .rx_remote_i,
    .obj0_data_i, .obj1_data_i, .tx_req_o, .tx_id_o, .tx_len_o, .tx_data_o, .tx_ack_i);
  tpos_ctrl_model i_tpos_ctrl_model (.clock_i, .slow_i(slow), .tx_req_i(tx_req_o),
    .tx_ack_o(tx_ack_i));

  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (tx_req_o === 1'b1 && tx_ack_i === 1'b1)
    begin
      fq.push_back({tx_len_o, tx_id_o, tx_data_o});
      tq.push_back(cyc);
    end
  end

  // ****
  // helpers
  // ****
  function automatic logic [3:0] plen(input int n);
    return 4'(n * 16 / 8);
  endfunction
  function automatic logic [63:0] msk(input int n);
    return {64{1'b1}} >> (64 - 16 * n);
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 chk({32'h0, reg_rdata_o}, {32'h0, e});
  endtask
  // count 0 first, edit, then count re-enables the object
  task automatic cfg(input bit o, input logic [7:0] tt, input logic [15:0] inh,
                     input logic [15:0] ev, input int n);
    logic [7:0] b;
    b = {3'h0, o, 4'h0};
    wr(b + 8'h08, 32'h0);
    for (int i = 0; i < n; i++)
      wr(b + 8'h09 + 8'(i), 32'h2002_0010 + 32'(i << 16));
    wr(b + 8'h02, {24'h0, tt});
    wr(b + 8'h03, {16'h0, inh});
    wr(b + 8'h05, {16'h0, ev});
    wr(b + 8'h08, 32'(n));
  endtask
  task automatic rx(input logic [10:0] id, input logic rem);
    @(posedge clock_i);
    rx_id_i     <= id;
    rx_remote_i <= rem;
    rx_valid_i  <= 1'b1;
    @(posedge clock_i);
    rx_valid_i <= 1'b0;
  endtask
  task automatic exp_frm(input logic [10:0] id, input int n, input logic [63:0] d);
    logic [78:0] f;
    f = '0;
    repeat (2000)
      if (fq.size() == 0)
        @(posedge clock_i);
    if (fq.size() != 0)
    begin
      f = fq.pop_front();
      t_prev = t_last;
      t_last = tq.pop_front();
    end
    chk({49'h0, f[78:64]}, {49'h0, plen(n), id});
    chk(f[63:0] & msk(n), d & msk(n));
  endtask
  task automatic no_frm(input int k);
    repeat (k) @(posedge clock_i);
    chk(64'(fq.size()), 64'h0);
  endtask

  // ****
  // main sequence
  // ****
  initial
  begin
    logic [63:0] d;
    int          g;
    void'($urandom(17409));
    {reg_wr_i, reg_rd_i, rx_valid_i, rx_remote_i, operational_i, slow} = '0;
    reg_addr_i  = '0;
    reg_wdata_i = '0;
    rx_id_i     = '0;
    obj0_data_i = {$urandom, $urandom};
    obj1_data_i = {$urandom, $urandom};
    resetn_i    = 1'b0;
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    rd(8'h00, 32'h5);
    rd(8'h10, 32'h5);
    rd(8'h02, 32'hFE);
    rd(8'h05, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h20, 32'h80);
    rd(8'h01, 32'h181);
    rd(8'h11, 32'h281);
    rd(8'h21, 32'h0);
    rd(8'h3F, 32'h0);
    wr(8'h01, 32'h1FFF_F9A5);
    rd(8'h01, 32'h0000_01A5);
    wr(8'h01, 32'h180);
    cfg(0, 8'h00, 16'h0, 16'h0, 2);
    wr(8'h09, 32'h1234_5608);
    rd(8'h09, 32'h2002_0010);
    wr(8'h08, 32'h5);
    rd(8'h08, 32'h2);
    operational_i <= 1'b1;
    rx(11'h080, 1'b0);
    exp_frm(11'h180, 2, obj0_data_i);
    no_frm(100);
    foreach (nl[k])
    begin
      cfg(0, 8'(nl[k]), 16'h0, 16'h0, 2);
      repeat (2 * nl[k])
      begin
        rx(11'h080, 1'b0);
        repeat (8) @(posedge clock_i);
      end
      chk(64'(fq.size()), 64'h2);
      fq.delete();
      tq.delete();
    end
    operational_i <= 1'b0;
    cfg(0, 8'h01, 16'h0, 16'h0, 2);
    rx(11'h080, 1'b0);
    no_frm(30);
    operational_i <= 1'b1;
    wr(8'h01, 32'h8000_0180);
    rx(11'h080, 1'b0);
    no_frm(30);
    wr(8'h01, 32'h180);
    cfg(0, 8'hFD, 16'h0, 16'h0, 2);
    rx(11'h181, 1'b1);
    no_frm(20);
    obj0_data_i <= {$urandom, $urandom};
    rx(11'h180, 1'b1);
    exp_frm(11'h180, 2, obj0_data_i);
    cfg(0, 8'hFC, 16'h0, 16'h0, 2);
    rx(11'h080, 1'b0);
    no_frm(20);
    d = obj0_data_i;
    obj0_data_i <= ~d;
    rx(11'h180, 1'b1);
    exp_frm(11'h180, 2, d);
    slow <= 1'b1;
    cfg(0, 8'h01, 16'h0, 16'h0, 2);
    cfg(1, 8'h01, 16'h0, 16'h0, 4);
    rx(11'h080, 1'b0);
    exp_frm(11'h180, 2, obj0_data_i);
    exp_frm(11'h281, 4, obj1_data_i);
    slow <= 1'b0;
    wr(8'h18, 32'h0);
    cfg(0, 8'hFE, 16'h0, 16'h2, 2);
    exp_frm(11'h180, 2, obj0_data_i);
    exp_frm(11'h180, 2, obj0_data_i);
    g = t_last - t_prev;
    chk(64'(g >= 798 && g <= 802), 64'h1);
    for (int inh = 5; inh >= 0; inh -= 5)
    begin
      cfg(0, 8'hFF, 16'(inh), 16'h0, 2);
      repeat (300) @(posedge clock_i);
      fq.delete();
      tq.delete();
      d = {$urandom, $urandom};
      obj0_data_i <= d;
      exp_frm(11'h180, 2, d);
      d = ~d;
      obj0_data_i <= d;
      exp_frm(11'h180, 2, d);
      g = t_last - t_prev;
      chk(64'(inh == 0 ? g < 40 : g >= 160 && g <= 245), 64'h1);
    end
    wrap_up();
  end
  initial
  begin
    repeat (40000) @(posedge clock_i);
    err_total++;
    wrap_up();
  end
endmodule

bind tpos_top tpos_top_chk i_tpos_top_chk (.clock_i, .resetn_i, .reg_addr_i, .reg_rd_i,
  .reg_rdata_o, .operational_i, .tx_req_o, .tx_id_o, .tx_len_o, .tx_data_o, .tx_ack_i);
